// *** logic/i2s_audio_cfg.svh ***
`ifndef I2S_AUDIO_CFG_SVH
`define I2S_AUDIO_CFG_SVH

// core clock and frame timing
`define I2S_CORE_CLK_HZ 40000000
`define I2S_FRAME_RATE_HZ 48000
`define I2S_WORD_BITS 16
`define I2S_BPF_SHORT 32
`define I2S_BPF_LONG 50

// bit clock rates follow from frame rate and frame length
`define I2S_BCLK_SHORT_HZ (`I2S_FRAME_RATE_HZ * `I2S_BPF_SHORT)
`define I2S_BCLK_LONG_HZ (`I2S_FRAME_RATE_HZ * `I2S_BPF_LONG)
`define I2S_SLAVE_BCLK_MAX_HZ 3072000

// least high or low phase, percent of the bit clock period
`define I2S_MIN_PHASE_PCT 35

// divider: the phase toggles at num/den of the core rate (two per period)
`define I2S_DIV_SCALE 1000
`define I2S_DIV_DEN (`I2S_CORE_CLK_HZ / `I2S_DIV_SCALE)
`define I2S_DIV_NUM_SHORT (2 * `I2S_BCLK_SHORT_HZ / `I2S_DIV_SCALE)
`define I2S_DIV_NUM_LONG (2 * `I2S_BCLK_LONG_HZ / `I2S_DIV_SCALE)

`endif

// *** logic/i2s_audio_pkg.sv ***
package i2s_audio_pkg;
	`include "i2s_audio_cfg.svh"

	// one stereo frame, left word in the low half
	typedef struct packed {
		logic [`I2S_WORD_BITS-1:0] right;
		logic [`I2S_WORD_BITS-1:0] left;
	} audio_frame_s;

	// bit clock edge events, one core cycle each
	typedef struct packed {
		logic rise;
		logic fall;
	} bclk_evt_s;

	// transmit slot progress
	typedef enum logic [2:0] {
		TX_IDLE = 3'b001,
		TX_DATA = 3'b010,
		TX_PAD = 3'b100
	} tx_state_e;
endpackage

// *** logic/i2s_bclk_divider.sv ***
`timescale 1ns/10ps
`include "i2s_audio_cfg.svh"
module i2s_bclk_divider import i2s_audio_pkg::*; #(
	parameter int DIV_W = 16
) (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	// control
	input wire logic run_i,
	input wire logic [DIV_W-1:0] num_i,
	input wire logic [DIV_W-1:0] den_i,
	// generated clock
	output logic sck_o,
	output bclk_evt_s evt_o
);
	logic [DIV_W-1:0] acc_reg, acc_next;
	logic sck_reg, sck_next;
	logic [DIV_W:0] sum;
	logic toggle;

	// fractional n/m accumulator; phase length varies by at most one
	// core cycle, so the mark/space ratio stays near one half at rates well below the core rate
	always_comb begin
		sum = {1'b0, acc_reg} + {1'b0, num_i};
		toggle = run_i && ce_i && (sum >= {1'b0, den_i});
		acc_next = acc_reg;
		sck_next = sck_reg;
		if (!run_i) begin
			acc_next = '0;
			sck_next = 1'b0;
		end else if (ce_i) begin
			acc_next = toggle ? DIV_W'(sum - {1'b0, den_i}) : sum[DIV_W-1:0];
			sck_next = toggle ? !sck_reg : sck_reg;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			acc_reg <= '0;
			sck_reg <= 1'b0;
		end else if (ce_i) begin
			acc_reg <= acc_next;
			sck_reg <= sck_next;
		end
	end

	// events mark the cycle before the pin level changes; the pin follows at the closing core clock edge
	assign evt_o.rise = toggle && !sck_reg;
	assign evt_o.fall = toggle && sck_reg;
	assign sck_o = sck_reg;

	// helper: length of the current phase in core cycles
	logic [DIV_W-1:0] hcnt_reg;
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i)
			hcnt_reg <= '0;
		else if (ce_i)
			hcnt_reg <= (toggle || !run_i) ? '0 : DIV_W'(hcnt_reg + 1'b1);
	end

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);

	AST_ACC_RANGE: assert property (run_i |-> acc_reg < den_i)
		else $error("divider accumulator out of range");
	AST_MIN_PHASE: assert property (
		toggle |-> (32'(hcnt_reg) + 1) * 32'(num_i) * 100 >=
			2 * `I2S_MIN_PHASE_PCT * 32'(den_i))
		else $error("bit clock phase shorter than allowed");
endmodule

// *** logic/i2s_audio_port.sv ***
`timescale 1ns/10ps
// Operation
// - in master mode bit clock and word select are driven out, in slave mode both are inputs.
// - the serial audio transmit line is an output in both modes.
// - channel words are 16 bits, MSB first, left MSB at the first data bit of the frame.
// - each word's MSB goes out one bit clock after the word select change, on a falling edge.
// - left samples travel while word select is low, right while it is high.
// - data changes on falling bit clock edges and is captured on the next rising edge.
// - one master rate gives 32 bit clocks per 48 kHz frame, a 1.536 MHz bit clock.
// - the other master rate gives 50 bit clocks per 48 kHz frame, a 2.400 MHz bit clock.
// - the master bit clock comes from the reference clock through an n/m fractional divider.
// - in slave mode any bit clock rate up to 3.072 MHz is followed.
// - the master bit clock keeps a mark/space ratio near one half, phases differing by at most one core cycle, each at least 0.35 of the period.
`include "i2s_audio_cfg.svh"
module i2s_audio_port import i2s_audio_pkg::*; #(
	parameter int WORD_BITS = `I2S_WORD_BITS,
	parameter int DIV_W = 16
) (
	// clock, reset, enable
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	// configuration
	input wire logic enable_i,
	input wire logic master_i,
	input wire logic rate_long_i,
	// bit clock pin
	input wire logic sck_i,
	output logic sck_o,
	output logic sck_oe_o,
	// word select pin
	input wire logic ws_i,
	output logic ws_o,
	output logic ws_oe_o,
	// serial data pins
	output logic serial_audio_tx_o,
	input wire logic serial_audio_rx_i,
	// user side
	input wire audio_frame_s tx_frame_i,
	output logic tx_take_o,
	output audio_frame_s rx_frame_o,
	output logic rx_valid_o
);
	localparam logic [5:0] BPF_SHORT = 6'(`I2S_BPF_SHORT);
	localparam logic [5:0] BPF_LONG = 6'(`I2S_BPF_LONG);
	localparam logic [DIV_W-1:0] NUM_SHORT = DIV_W'(`I2S_DIV_NUM_SHORT);
	localparam logic [DIV_W-1:0] NUM_LONG = DIV_W'(`I2S_DIV_NUM_LONG);
	localparam logic [DIV_W-1:0] DIV_DEN = DIV_W'(`I2S_DIV_DEN);
	localparam logic [4:0] WBITS = 5'(WORD_BITS);

	logic run, master_run;
	logic [5:0] bpf;
	logic div_sck;
	bclk_evt_s div_evt, evt;

	assign run = enable_i;
	assign master_run = enable_i && master_i;
	assign bpf = rate_long_i ? BPF_LONG : BPF_SHORT;

	// master bit clock source
	i2s_bclk_divider #(.DIV_W(DIV_W)) u_div (
		.core_clk_i(core_clk_i),
		.rst_n_i(rst_n_i),
		.ce_i(ce_i),
		.run_i(master_run),
		.num_i(rate_long_i ? NUM_LONG : NUM_SHORT),
		.den_i(DIV_DEN),
		.sck_o(div_sck),
		.evt_o(div_evt)
	);

	// pin direction and slave edge detection state
	logic sck_prev_reg, sck_prev_next;
	logic oe_reg, oe_next;

	// slave edges come from the sampled pin; a clock whose phases meet
	// the 0.35 floor lasts many core cycles per phase, so none is lost
	always_comb begin
		sck_prev_next = ce_i ? sck_i : sck_prev_reg;
		oe_next = ce_i ? master_run : oe_reg;
		if (master_i) begin
			evt = div_evt;
		end else begin
			evt.rise = run && ce_i && sck_i && !sck_prev_reg;
			evt.fall = run && ce_i && !sck_i && sck_prev_reg;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			sck_prev_reg <= 1'b0;
			oe_reg <= 1'b0;
		end else if (ce_i) begin
			sck_prev_reg <= sck_prev_next;
			oe_reg <= oe_next;
		end
	end

	assign sck_o = div_sck;
	assign sck_oe_o = oe_reg;
	assign ws_oe_o = oe_reg;

	// framing: master word select and the per-rise view of the line
	logic [5:0] pos_reg, pos_next;
	logic ws_out_reg, ws_out_next;
	logic ws_rise_reg, ws_rise_next;
	logic ws_chg_reg, ws_chg_next;
	logic ws_line;

	// master changes word select on falling edges; both modes sample the
	// line on rising edges so a change is seen one half period later
	always_comb begin
		ws_line = master_i ? ws_out_reg : ws_i;
		pos_next = pos_reg;
		ws_out_next = ws_out_reg;
		ws_rise_next = ws_rise_reg;
		ws_chg_next = ws_chg_reg;
		if (!run) begin
			pos_next = '0;
			ws_out_next = 1'b0;
			ws_rise_next = 1'b0;
			ws_chg_next = 1'b0;
		end else begin
			if (master_i && evt.fall) begin
				pos_next = (pos_reg >= bpf - 6'd1) ? 6'd0 : pos_reg + 6'd1;
				ws_out_next = pos_next >= (bpf >> 1);
			end
			if (evt.rise) begin
				ws_rise_next = ws_line;
				ws_chg_next = ws_line != ws_rise_reg;
			end
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			pos_reg <= '0;
			ws_out_reg <= 1'b0;
			ws_rise_reg <= 1'b0;
			ws_chg_reg <= 1'b0;
		end else if (ce_i) begin
			pos_reg <= pos_next;
			ws_out_reg <= ws_out_next;
			ws_rise_reg <= ws_rise_next;
			ws_chg_reg <= ws_chg_next;
		end
	end

	assign ws_o = ws_out_reg;

	// transmit path
	tx_state_e tx_state_reg, tx_state_next;
	logic [WORD_BITS-1:0] tx_shift_reg, tx_shift_next;
	logic [WORD_BITS-1:0] tx_hold_reg, tx_hold_next;
	logic [4:0] tx_cnt_reg, tx_cnt_next;
	logic tx_bit_reg, tx_bit_next;
	logic tx_take_reg, tx_take_next;
	logic tx_load;
	logic [WORD_BITS-1:0] tx_word;

	// a word loads on the first falling edge after word select changed;
	// the right word is caught with the left so a frame never tears
	always_comb begin
		tx_load = run && evt.fall && ws_chg_reg;
		tx_word = ws_rise_reg ? tx_hold_reg : tx_frame_i.left;
		tx_state_next = tx_state_reg;
		tx_shift_next = tx_shift_reg;
		tx_hold_next = tx_hold_reg;
		tx_cnt_next = tx_cnt_reg;
		tx_bit_next = tx_bit_reg;
		tx_take_next = 1'b0;
		if (!run) begin
			tx_state_next = TX_IDLE;
			tx_cnt_next = WBITS;
			tx_bit_next = 1'b0;
		end else if (tx_load) begin
			tx_state_next = TX_DATA;
			tx_bit_next = tx_word[WORD_BITS-1];
			tx_shift_next = {tx_word[WORD_BITS-2:0], 1'b0};
			tx_cnt_next = 5'd1;
			if (!ws_rise_reg) begin
				tx_hold_next = tx_frame_i.right;
				tx_take_next = 1'b1;
			end
		end else if (evt.fall) begin
			unique case (tx_state_reg)
				TX_IDLE: begin
					tx_bit_next = 1'b0;
				end
				TX_DATA: begin
					tx_bit_next = tx_shift_reg[WORD_BITS-1];
					tx_shift_next = {tx_shift_reg[WORD_BITS-2:0], 1'b0};
					tx_cnt_next = tx_cnt_reg + 5'd1;
					if (tx_cnt_reg + 5'd1 >= WBITS)
						tx_state_next = TX_PAD;
				end
				TX_PAD: begin
					tx_bit_next = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			tx_state_reg <= TX_IDLE;
			tx_shift_reg <= '0;
			tx_hold_reg <= '0;
			tx_cnt_reg <= WBITS;
			tx_bit_reg <= 1'b0;
			tx_take_reg <= 1'b0;
		end else if (ce_i) begin
			tx_state_reg <= tx_state_next;
			tx_shift_reg <= tx_shift_next;
			tx_hold_reg <= tx_hold_next;
			tx_cnt_reg <= tx_cnt_next;
			tx_bit_reg <= tx_bit_next;
			tx_take_reg <= tx_take_next;
		end
	end

	assign serial_audio_tx_o = tx_bit_reg;
	assign tx_take_o = tx_take_reg;

	// receive path
	logic [WORD_BITS-1:0] rx_shift_reg, rx_shift_next;
	logic [WORD_BITS-1:0] rx_left_reg, rx_left_next;
	logic [4:0] rx_cnt_reg, rx_cnt_next;
	logic rx_ch_reg, rx_ch_next;
	audio_frame_s rx_frame_reg, rx_frame_next;
	logic rx_valid_reg, rx_valid_next;
	logic [WORD_BITS-1:0] rx_word;

	// the rise that sees word select change still carries the last bit of
	// the old slot, so capture runs before the counter restarts
	always_comb begin
		rx_word = {rx_shift_reg[WORD_BITS-2:0], serial_audio_rx_i};
		rx_shift_next = rx_shift_reg;
		rx_left_next = rx_left_reg;
		rx_cnt_next = rx_cnt_reg;
		rx_ch_next = rx_ch_reg;
		rx_frame_next = rx_frame_reg;
		rx_valid_next = 1'b0;
		if (!run) begin
			rx_cnt_next = WBITS;
			rx_ch_next = 1'b0;
		end else if (evt.rise) begin
			if (rx_cnt_reg < WBITS) begin
				rx_shift_next = rx_word;
				rx_cnt_next = rx_cnt_reg + 5'd1;
				if (rx_cnt_reg == WBITS - 5'd1) begin
					if (!rx_ch_reg) begin
						rx_left_next = rx_word;
					end else begin
						rx_frame_next.left = rx_left_reg;
						rx_frame_next.right = rx_word;
						rx_valid_next = 1'b1;
					end
				end
			end
			if (ws_line != ws_rise_reg) begin
				rx_cnt_next = '0;
				rx_ch_next = ws_line;
			end
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			rx_shift_reg <= '0;
			rx_left_reg <= '0;
			rx_cnt_reg <= WBITS;
			rx_ch_reg <= 1'b0;
			rx_frame_reg <= '0;
			rx_valid_reg <= 1'b0;
		end else if (ce_i) begin
			rx_shift_reg <= rx_shift_next;
			rx_left_reg <= rx_left_next;
			rx_cnt_reg <= rx_cnt_next;
			rx_ch_reg <= rx_ch_next;
			rx_frame_reg <= rx_frame_next;
			rx_valid_reg <= rx_valid_next;
		end
	end

	assign rx_frame_o = rx_frame_reg;
	assign rx_valid_o = rx_valid_reg;

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);

	AST_PIN_DIR: assert property (
		ce_i |=> (sck_oe_o == $past(master_run)) && (ws_oe_o == sck_oe_o))
		else $error("pin direction does not follow mode");
	AST_LEFT_MSB: assert property (
		tx_load && !ws_rise_reg |=>
			serial_audio_tx_o == $past(tx_frame_i.left[WORD_BITS-1]))
		else $error("left msb not launched after word select");
	AST_RIGHT_WORD: assert property (
		tx_load && !ws_rise_reg |=> tx_hold_reg == $past(tx_frame_i.right))
		else $error("right word not held with its left word");
	AST_TX_HOLD: assert property (
		run && !evt.fall |=> $stable(serial_audio_tx_o))
		else $error("transmit data moved off a falling edge");
	AST_ZERO_PAD: assert property (
		evt.fall && !ws_chg_reg && tx_state_reg == TX_PAD |=>
			!serial_audio_tx_o)
		else $error("padding bit not zero");
	AST_WORD_LEN: assert property (
		tx_load |=> tx_cnt_reg == 5'd1 ##0 (tx_state_reg == TX_DATA))
		else $error("word load did not restart bit count");
	AST_FRAME_WRAP: assert property (
		master_run && evt.fall && pos_reg == bpf - 6'd1 |=>
			pos_reg == 6'd0 && !ws_o)
		else $error("master frame length wrong");
	AST_WS_HALF: assert property (
		master_run && evt.fall && pos_reg == (bpf >> 1) - 6'd1 |=> ws_o)
		else $error("word select not high for the right slot");
	AST_SLAVE_EDGE: assert property (
		run && !master_i && ce_i && $past(ce_i) && $rose(sck_i) |-> evt.rise)
		else $error("slave rising edge missed");

	COV_RX_FRAME: cover property (rx_valid_o);
	COV_LONG_WRAP: cover property (
		master_run && rate_long_i && evt.fall && pos_reg == BPF_LONG - 6'd1);
	COV_SLAVE_LOAD: cover property (!master_i && tx_load);
	COV_PAD: cover property (tx_state_reg == TX_PAD && evt.fall);
endmodule

// *** dv/i2s_peer_model.sv ***
`timescale 1ns/10ps
// far-end audio peer: bit clock master in slave tests, listener always
module i2s_peer_model import i2s_audio_pkg::*; #(
	parameter int HALF_NS = 175
) (
	// control
	input wire logic clk_run_i,
	input wire logic [7:0] bpf_i,
	input wire audio_frame_s tx_frame_i,
	// resolved pins
	input wire logic sck_i,
	input wire logic ws_i,
	input wire logic sd_i,
	// peer drivers
	output logic sck_o,
	output logic ws_o,
	output logic sd_o,
	// captured frames
	output audio_frame_s rx_frame_o,
	output int frames_o,
	output logic pad_err_o
);
	logic ws_q;
	logic chg;
	logic [15:0] shreg;
	logic [15:0] left_q;
	int cnt;
	int j;

	// start outside a slot so the first partial slot is ignored
	initial begin
		sck_o = 1'h0;
		ws_o = 1'h0;
		sd_o = 1'h0;
		ws_q = 1'h0;
		chg = 1'h0;
		cnt = 16;
		j = 16;
		frames_o = 0;
		pad_err_o = 1'h0;
	end

	// whole frames only; the clock stands low between runs, and edges sit
	// off the core clock edge so the port never samples in a race
	always begin
		wait (clk_run_i);
		if (!sck_o)
			#(HALF_NS / 2);
		for (int p = 0; p < bpf_i; p++) begin
			sck_o = 1'h0;
			if (p == 0)
				ws_o = 1'h0;
			else if (p == bpf_i / 2)
				ws_o = 1'h1;
			#(HALF_NS) sck_o = 1'h1;
			#(HALF_NS);
		end
		if (!clk_run_i)
			sck_o = 1'h0;
	end

	// capture on rise; the bit that shows a ws change ends the old slot
	always @(posedge sck_i) begin
		if (cnt < 16) begin
			shreg = {shreg[14:0], sd_i};
			cnt++;
			if (cnt == 16 && !ws_q)
				left_q = shreg;
			if (cnt == 16 && ws_q) begin
				rx_frame_o = {shreg, left_q};
				frames_o++;
			end
		end else if (sd_i !== 1'h0) begin
			pad_err_o = 1'h1;
		end
		chg = (ws_i !== ws_q);
		if (chg)
			cnt = 0;
		ws_q = ws_i;
	end

	// launch on fall, msb one bit after the ws change, zero pad after
	always @(negedge sck_i) begin
		j = chg ? 0 : (j < 16 ? j + 1 : j);
		if (j < 16)
			sd_o = ws_q ? tx_frame_i.right[15-j] : tx_frame_i.left[15-j];
		else
			sd_o = 1'h0;
	end
endmodule

// *** dv/test_i2s_audio_port.sv ***
`timescale 1ns/10ps
module test_i2s_audio_port import i2s_audio_pkg::*;;
	localparam int FR = 40000000 / 48000;
	logic core_clk_i, rst_n_i, enable_i, master_i, rate_long_i, peer_run;
	logic sck_o, sck_oe_o, ws_o, ws_oe_o, serial_audio_tx_o;
	logic tx_take_o, rx_valid_o, p_sck, p_ws, p_sd, pad_err, sck_w, ws_w;
	logic [7:0] bpf;
	audio_frame_s tx_frame_i, rx_frame_o, peer_tx, peer_rx;
	int peer_frames, miscompares = 0, total_checks = 0, cycles = 0;

	// pin levels: whoever has the enable drives the wire
	assign sck_w = sck_oe_o ? sck_o : p_sck;
	assign ws_w = ws_oe_o ? ws_o : p_ws;

	i2s_audio_port u_dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
		.ce_i(1'h1), .enable_i(enable_i), .master_i(master_i),
		.rate_long_i(rate_long_i), .sck_i(sck_w), .sck_o(sck_o),
		.sck_oe_o(sck_oe_o), .ws_i(ws_w), .ws_o(ws_o), .ws_oe_o(ws_oe_o),
		.serial_audio_tx_o(serial_audio_tx_o), .serial_audio_rx_i(p_sd),
		.tx_frame_i(tx_frame_i), .tx_take_o(tx_take_o),
		.rx_frame_o(rx_frame_o), .rx_valid_o(rx_valid_o));

	i2s_peer_model u_peer (.clk_run_i(peer_run), .bpf_i(bpf),
		.tx_frame_i(peer_tx), .sck_i(sck_w), .ws_i(ws_w),
		.sd_i(serial_audio_tx_o), .sck_o(p_sck), .ws_o(p_ws), .sd_o(p_sd),
		.rx_frame_o(peer_rx), .frames_o(peer_frames), .pad_err_o(pad_err));

	initial core_clk_i = 1'h0;
	always #12.5 core_clk_i = ~core_clk_i;

	task automatic give_verdict();
		if (miscompares == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] exp,
			input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %s expected %h got %h", name, exp, got);
		end
	endtask

	// one full ws period from rise to rise, seen at the core clock
	task automatic measure(input logic [7:0] b);
		int cyc, rises, ph, minp, takes, seen, vals;
		logic s_q, w_q;
		cyc = 0;
		rises = 0;
		ph = 0;
		minp = 1000;
		takes = 0;
		seen = 0;
		vals = 0;
		s_q = sck_o;
		w_q = ws_o;
		while (seen < 2 && cyc < 3000) begin
			@(posedge core_clk_i);
			if (seen == 1) begin
				cyc++;
				takes += tx_take_o;
				vals += rx_valid_o;
			end
			if (sck_o !== s_q) begin
				if (seen == 1 && ph < minp)
					minp = ph;
				if (seen == 1 && sck_o)
					rises++;
				ph = 0;
			end
			ph++;
			if (ws_o && !w_q)
				seen++;
			s_q = sck_o;
			w_q = ws_o;
		end
		chk("frame_len", 1'h1, cyc inside {FR, FR + 1});
		chk("sck_per_frame", b, rises);
		chk("min_phase", 1'h1, minp * 100 * b >= 35 * cyc);
		chk("takes", 1'h1, takes);
		chk("rx_valid", 1'h1, vals);
	endtask

	task automatic wait_frames(input int n);
		int target;
		target = peer_frames + n;
		for (int i = 0; i < 8000 && peer_frames < target; i++)
			@(posedge core_clk_i);
	endtask

	// mode changes only while the port is disabled
	task automatic run(input logic m, input logic r, input logic [7:0] b,
			input audio_frame_s tx, input audio_frame_s ptx);
		@(posedge core_clk_i);
		enable_i <= 1'h0;
		repeat (2) @(posedge core_clk_i);
		master_i <= m;
		rate_long_i <= r;
		tx_frame_i <= tx;
		peer_tx <= ptx;
		bpf <= b;
		repeat (2) @(posedge core_clk_i);
		enable_i <= 1'h1;
		repeat (3) @(posedge core_clk_i);
		chk("sck_oe", m, sck_oe_o);
		chk("ws_oe", m, ws_oe_o);
		peer_run <= !m;
		if (m)
			measure(b);
		wait_frames(5);
		chk("peer_rx", tx, peer_rx);
		chk("dut_rx", ptx, rx_frame_o);
		peer_run <= 1'h0;
	endtask

	// cut a hang short
	always @(posedge core_clk_i) begin
		cycles++;
		if (cycles == 30000) begin
			miscompares++;
			give_verdict();
		end
	end

	initial begin
		rst_n_i = 1'h0;
		enable_i = 1'h0;
		master_i = 1'h0;
		rate_long_i = 1'h0;
		peer_run = 1'h0;
		bpf = 8'h20;
		tx_frame_i = '0;
		peer_tx = '0;
		repeat (3) @(posedge core_clk_i);
		rst_n_i <= 1'h1;
		@(posedge core_clk_i);
		chk("sck_oe", 1'h0, sck_oe_o);
		chk("ws_oe", 1'h0, ws_oe_o);
		run(1'h1, 1'h0, 8'h20, 32'h3C96A55A, 32'hFEDC1234);
		run(1'h1, 1'h1, 8'h32, 32'h0F0FF0F1, 32'h8001C3E7);
		run(1'h0, 1'h0, 8'h20, 32'h5AA5E01F, 32'h7FFE0180);
		chk("pad_zero", 1'h0, pad_err);
		give_verdict();
	end
endmodule
